// ==== bwlm_pkg.sv ====
// bwlm_pkg: organisation constants and read sequencer states for the
// lane-masked burst write memory.
// assumes: included first; all users refer to names as bwlm_pkg::name.
package bwlm_pkg;

    // ********************************
    // organisations (width, lanes)
    // ********************************
    localparam int ORG8_W     = 8;
    localparam int ORG8_LANES = 2;
    localparam int ORG9_W     = 9;
    localparam int ORG9_LANES = 1;
    localparam int ORG18_W    = 18;
    localparam int ORG18_LANES = 2;
    localparam int ORG36_W    = 36;
    localparam int ORG36_LANES = 4;

    // ********************************
    // defaults and timing
    // ********************************
    localparam int DEF_ADDR_W   = 6;
    localparam int SYNC_STAGES  = 3;
    localparam int STRAP_WAIT   = 4;
    localparam int BURST_LEN    = 2;
    localparam logic [0:0] WORD0_OFS = 1'h0;
    localparam logic [0:0] WORD1_OFS = 1'h1;

    typedef enum logic [5:0] {
        RD_IDLE  = 6'h01,
        RD_ARMED = 6'h02,
        RD_FIRST = 6'h04,
        RD_SECOND = 6'h08,
        RD_HOLD  = 6'h10,
        RD_DONE  = 6'h20
    } bwlm_rd_e;

endpackage

// ==== bwlm_sync.sv ====
// bwlm_sync: three-stage pin synchroniser with agreement filter.
// assumes: inputs asynchronous to clk; output updates only per bit once
// stages two and three agree.
`timescale 1ns/1ns
module bwlm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ********************************
    // per-bit agreement filter
    // ********************************
    // reset to all ones: selects read as deasserted until pins settle
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                pin_out[i] <= 1'h1;
            end else if (s2_reg[i] == s3_reg[i]) begin
                pin_out[i] <= s3_reg[i];
            end
        end
    end
endmodule

// ==== bwlm_top.sv ====
// bwlm_top: lane-masked double-rate burst write port with a small read
// port, modelled on one system clock that samples the memory clock pins.
// assumes: memory clock pins run far slower than SYS_CLK so every edge is
// seen; the controller keeps selects and data stable around each edge.
// Function
// - write data taken on true and complementary clock rises.
// - first portion goes to location plus zero, second to plus one.
// - x8 with both nibble selects low writes all eight bits.
// - x8 single nibble select writes its nibble only, other unchanged.
// - x18 with both lane selects low writes all eighteen bits.
// - x18 single lane select writes its nine bits only.
// - x9 single select: low writes the word, high writes nothing.
// - x36 with all four selects low writes all thirty-six bits.
// - x36 selects enable nine-bit lanes; unselected lanes keep contents.
// - all selects high: nothing written, location unchanged.
// - each portion uses its own selects, may change between portions.
// - after power-up both ports deselected, read outputs high impedance.
// - read data on output clock rises, input clocks in single mode.
`timescale 1ns/1ns
module bwlm_top #(
    parameter int DATA_W = bwlm_pkg::ORG18_W,
    parameter int LANES  = bwlm_pkg::ORG18_LANES,
    parameter int ADDR_W = bwlm_pkg::DEF_ADDR_W
) (
    input  wire logic              SYS_CLK,
    input  wire logic              RST_B,
    input  wire logic              K_IN,
    input  wire logic              K_B_IN,
    input  wire logic              C_IN,
    input  wire logic              C_B_IN,
    input  wire logic              READ_PORT_SEL_N,
    input  wire logic              WRITE_PORT_SEL_N,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] D,
    input  wire logic [LANES-1:0]  LANE_WRITE_MASK_N,
    output logic      [DATA_W-1:0] Q,
    output logic                   Q_OE
);
    localparam int LW    = DATA_W / LANES;
    localparam int IDX_W = ADDR_W + 1;
    localparam int WORDS = bwlm_pkg::BURST_LEN << ADDR_W;
    localparam int SW    = 6 + ADDR_W + DATA_W + LANES;

    // ********************************
    // pin synchronisation
    // ********************************
    logic [SW-1:0]     pins_s;
    logic              k_s;
    logic              kb_s;
    logic              c_s;
    logic              cb_s;
    logic              rps_n_s;
    logic              write_port_sel_n;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] d_s;
    logic [LANES-1:0]  lane_write_mask_n;

    bwlm_sync #(.W(SW)) u_sync (
        .clk     (SYS_CLK),
        .rst_b   (RST_B),
        .pin_in  ({K_IN, K_B_IN, C_IN, C_B_IN, READ_PORT_SEL_N,
                   WRITE_PORT_SEL_N, ADDR, D, LANE_WRITE_MASK_N}),
        .pin_out (pins_s)
    );

    assign {k_s, kb_s, c_s, cb_s, rps_n_s, write_port_sel_n, addr_s, d_s,
            lane_write_mask_n} = pins_s;

    // ********************************
    // clock edge detection
    // ********************************
    logic [3:0] clk_pins_reg;
    logic       k_rise;
    logic       kb_rise;
    logic       c_rise;
    logic       cb_rise;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            clk_pins_reg <= 4'hf;
        end else begin
            clk_pins_reg <= {k_s, kb_s, c_s, cb_s};
        end
    end

    assign k_rise  = k_s  & ~clk_pins_reg[3];
    assign kb_rise = kb_s & ~clk_pins_reg[2];
    assign c_rise  = c_s  & ~clk_pins_reg[1];
    assign cb_rise = cb_s & ~clk_pins_reg[0];

    // ********************************
    // single clock strap
    // ********************************
    // output clock pins both high shortly after reset release select
    // single clock mode; fixed until the next reset
    logic [2:0] strap_cnt_reg;
    logic       strap_done_reg;
    logic       single_mode_reg;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_cnt_reg   <= 3'h0;
            strap_done_reg  <= 1'h0;
            single_mode_reg <= 1'h0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 3'h1;
            if (strap_cnt_reg == 3'(bwlm_pkg::STRAP_WAIT)) begin
                strap_done_reg  <= 1'h1;
                single_mode_reg <= c_s & cb_s;
            end
        end
    end

    logic out_rise;
    logic out_b_rise;

    assign out_rise   = single_mode_reg ? k_rise  : c_rise;
    assign out_b_rise = single_mode_reg ? kb_rise : cb_rise;

    // ********************************
    // write port
    // ********************************
    logic              wr_pend_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic              wr_start;
    logic              wr_go;
    logic [IDX_W-1:0]  wr_idx;

    // new writes wait for the strap capture so an early glitch is ignored
    assign wr_start = k_rise & ~write_port_sel_n & strap_done_reg;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_reg <= 1'h0;
            wr_addr_reg <= '0;
        end else if (wr_start) begin
            wr_pend_reg <= 1'h1;
            wr_addr_reg <= addr_s;
        end else if (kb_rise) begin
            wr_pend_reg <= 1'h0;
        end
    end

    // portion one on true rise, portion two on complementary rise
    assign wr_go  = wr_start | (kb_rise & wr_pend_reg);
    assign wr_idx = wr_start ? {addr_s, bwlm_pkg::WORD0_OFS}
                             : {wr_addr_reg, bwlm_pkg::WORD1_OFS};

    // ********************************
    // lane memories
    // ********************************
    // one array per lane: a select held high simply never enables that
    // lane's array, so no read-modify-write hazard on neighbours
    logic [IDX_W-1:0]  rd_idx;
    logic [DATA_W-1:0] rd_word;

    for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
        logic [LW-1:0] lane_mem [WORDS];

        // mask sampled with this portion's data only
        always_ff @(posedge SYS_CLK) begin
            if (wr_go && !lane_write_mask_n[ln]) begin
                lane_mem[wr_idx] <= d_s[ln*LW +: LW];
            end
        end

        assign rd_word[ln*LW +: LW] = lane_mem[rd_idx];
    end

    // ********************************
    // read port
    // ********************************
    bwlm_pkg::bwlm_rd_e rd_state_reg;
    logic [ADDR_W-1:0]  rd_addr_reg;

    assign rd_idx = {rd_addr_reg,
                     rd_state_reg == bwlm_pkg::RD_FIRST ?
                     bwlm_pkg::WORD0_OFS : bwlm_pkg::WORD1_OFS};

    // a read request is only taken while the sequencer is idle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_state_reg <= bwlm_pkg::RD_IDLE;
            rd_addr_reg  <= '0;
        end else begin
            unique case (rd_state_reg)
                bwlm_pkg::RD_IDLE: begin
                    if (k_rise && !rps_n_s && strap_done_reg) begin
                        rd_addr_reg  <= addr_s;
                        rd_state_reg <= bwlm_pkg::RD_ARMED;
                    end
                end
                bwlm_pkg::RD_ARMED: begin
                    if (k_rise) begin
                        rd_state_reg <= bwlm_pkg::RD_FIRST;
                    end
                end
                bwlm_pkg::RD_FIRST: begin
                    if (out_b_rise) begin
                        rd_state_reg <= bwlm_pkg::RD_SECOND;
                    end
                end
                bwlm_pkg::RD_SECOND: begin
                    if (out_rise) begin
                        rd_state_reg <= bwlm_pkg::RD_HOLD;
                    end
                end
                bwlm_pkg::RD_HOLD: begin
                    if (out_b_rise) begin
                        rd_state_reg <= bwlm_pkg::RD_DONE;
                    end
                end
                bwlm_pkg::RD_DONE: begin
                    rd_state_reg <= bwlm_pkg::RD_IDLE;
                end
                default: begin
                    rd_state_reg <= bwlm_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // word launched on the output clock edge that ends its wait state
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            Q    <= '0;
            Q_OE <= 1'h0;
        end else if ((rd_state_reg == bwlm_pkg::RD_FIRST && out_b_rise) ||
                     (rd_state_reg == bwlm_pkg::RD_SECOND && out_rise)) begin
            Q    <= rd_word;
            Q_OE <= 1'h1;
        end else if (rd_state_reg == bwlm_pkg::RD_HOLD && out_b_rise) begin
            Q_OE <= 1'h0;
        end
    end
endmodule

// ==== bwlm_top_props.sv ====
// bwlm_top_props: port assertions for bwlm_top.
// assumes: C pins tied high or moving with the K pins, slow memory clocks.
`timescale 1ns/1ns
module bwlm_top_props #(
    parameter int DATA_W = 18,
    parameter int LANES  = 2,
    parameter int ADDR_W = 6
) (
    input wire logic              SYS_CLK,
    input wire logic              RST_B,
    input wire logic              K_IN,
    input wire logic              K_B_IN,
    input wire logic              C_IN,
    input wire logic              C_B_IN,
    input wire logic              READ_PORT_SEL_N,
    input wire logic              WRITE_PORT_SEL_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] D,
    input wire logic [LANES-1:0]  LANE_WRITE_MASK_N,
    input wire logic [DATA_W-1:0] Q,
    input wire logic              Q_OE
);
    // ****
    // helpers and properties
    // ****
    logic [7:0] quiet_reg;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // saturates so a long idle never wraps back into the window
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B)
            quiet_reg <= 8'h00;
        else if (!READ_PORT_SEL_N)
            quiet_reg <= 8'h00;
        else if (quiet_reg != 8'hff)
            quiet_reg <= quiet_reg + 8'h01;
    end
    sequence s_oe_on;
        $rose(Q_OE);
    endsequence
    sequence s_launch;
        $changed(Q);
    endsequence
    AST_RST_OE: assert property ($rose(RST_B) |-> !Q_OE [*8])
        else $error("read drive on right after reset");
    AST_RST_Q: assert property ($rose(RST_B) |-> Q == '0)
        else $error("read data not cleared by reset");
    AST_OE_ON_KB: assert property (s_oe_on |-> K_B_IN)
        else $error("read drive began away from the bar clock");
    AST_OE_OFF_KB: assert property ($fell(Q_OE) |-> K_B_IN)
        else $error("read drive ended away from the bar clock");
    AST_LAUNCH: assert property (s_launch |-> Q_OE)
        else $error("read data moved while not driving");
    AST_A1_ON_K: assert property ($changed(Q) && Q_OE |-> K_IN)
        else $error("second word not on the true clock");
    AST_OE_WIDTH: assert property (s_oe_on |-> Q_OE [*8])
        else $error("read drive too short");
    AST_QUIET: assert property (quiet_reg > 8'h96 |-> !Q_OE)
        else $error("read drive without a read select");
endmodule
bind bwlm_top bwlm_top_props #(
    .DATA_W(DATA_W), .LANES(LANES), .ADDR_W(ADDR_W)
) bwlm_top_props_i (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .K_IN(K_IN), .K_B_IN(K_B_IN),
    .C_IN(C_IN), .C_B_IN(C_B_IN), .READ_PORT_SEL_N(READ_PORT_SEL_N),
    .WRITE_PORT_SEL_N(WRITE_PORT_SEL_N), .ADDR(ADDR), .D(D),
    .LANE_WRITE_MASK_N(LANE_WRITE_MASK_N), .Q(Q), .Q_OE(Q_OE)
);

// ==== bwlm_ctrl_model.sv ====
// bwlm_ctrl_model: memory controller on the write and read ports.
// assumes: clk is the system clock; pins change on its falling edge.
`timescale 1ns/1ns
module bwlm_ctrl_model #(
    parameter int PH = 10
) (
    input  wire logic        clk,
    output logic             k_o,
    output logic             kb_o,
    output logic             rsel_n_o,
    output logic             wsel_n_o,
    output logic [5:0]       addr_o,
    output logic [17:0]      d_o,
    output logic [1:0]       mask_n_o,
    input  wire logic [17:0] q_i,
    input  wire logic        q_oe_i
);
    // ****
    // one memory clock cycle
    // ****
    logic [17:0] qk;
    logic [17:0] qkb;
    logic        oek;
    logic        oekb;
    // clocks parked high between cycles for the quickest restart
    initial begin
        k_o = 1'h1;
        kb_o = 1'h1;
        rsel_n_o = 1'h1;
        wsel_n_o = 1'h1;
        addr_o = 6'h2a;
        d_o = 18'h15555;
        mask_n_o = 2'h3;
    end
    task automatic cyc(input logic rs_n, input logic ws_n,
        input logic [5:0] a, input logic [17:0] d0, input logic [1:0] m0,
        input logic [17:0] d1, input logic [1:0] m1);
        @(negedge clk);
        k_o = 1'h0;
        rsel_n_o = rs_n;
        wsel_n_o = ws_n;
        addr_o = a;
        d_o = ws_n ? ~d_o : d0;
        mask_n_o = m0;
        repeat (PH) @(negedge clk);
        k_o = 1'h1;
        repeat (PH) @(negedge clk);
        qk = q_i;
        oek = q_oe_i;
        kb_o = 1'h0;
        rsel_n_o = 1'h1;
        wsel_n_o = 1'h1;
        addr_o = ~addr_o;
        d_o = ws_n ? ~d_o : d1;
        mask_n_o = m1;
        repeat (PH) @(negedge clk);
        kb_o = 1'h1;
        repeat (PH) @(negedge clk);
        qkb = q_i;
        oekb = q_oe_i;
    endtask
endmodule

// ==== tb_top.sv ====
// tb_top: random lane-masked bursts read back through the read port.
// assumes: x18 organisation; pass one ties C pins high (single clock
// mode), pass two holds them low at strap time and then follows K.
`timescale 1ns/1ns
module tb_top;
    // ****
    // clock, design, controller
    // ****
    logic        sys_clk;
    logic        rst_b;
    logic        k;
    logic        kb;
    logic        rsel_n;
    logic        wsel_n;
    logic [5:0]  addr;
    logic [17:0] d;
    logic [1:0]  mask_n;
    logic [17:0] q;
    logic        q_oe;
    logic        dual;
    logic        c_live;
    logic        c_in;
    logic        cb_in;
    int          err_total;
    int          cmp_count;
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    // output clocks copy the input clocks so one set of checks fits both
    assign c_in  = dual ? k & c_live : 1'h1;
    assign cb_in = dual ? kb & c_live : 1'h1;
    bwlm_top bwlm_top_i (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .K_IN(k), .K_B_IN(kb),
        .C_IN(c_in), .C_B_IN(cb_in), .READ_PORT_SEL_N(rsel_n),
        .WRITE_PORT_SEL_N(wsel_n), .ADDR(addr), .D(d),
        .LANE_WRITE_MASK_N(mask_n), .Q(q), .Q_OE(q_oe)
    );
    bwlm_ctrl_model bwlm_ctrl_model_i (
        .clk(sys_clk), .k_o(k), .kb_o(kb), .rsel_n_o(rsel_n),
        .wsel_n_o(wsel_n), .addr_o(addr), .d_o(d), .mask_n_o(mask_n),
        .q_i(q), .q_oe_i(q_oe)
    );
    // ****
    // expectations and checks
    // ****
    function automatic logic [17:0] merge(input logic [17:0] old,
        input logic [17:0] nw, input logic [1:0] m_n);
        merge = old;
        if (!m_n[0])
            merge[8:0] = nw[8:0];
        if (!m_n[1])
            merge[17:9] = nw[17:9];
    endfunction
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (12000) @(posedge sys_clk);
        err_total++;
        close_out();
    end
    // ****
    // main sequence
    // ****
    initial begin
        logic [5:0]  a;
        logic [17:0] p0, p1, n0, n1;
        logic [1:0]  m0, m1;
        err_total = 0;
        cmp_count = 0;
        dual = 1'h0;
        c_live = 1'h0;
        a = 6'($urandom(32'hd30e706d));
        // pass two resets again mid-run with C low so the strap picks
        // two clock mode
        for (int ph = 0; ph < 2; ph++) begin
            dual = 1'(ph);
            c_live = 1'h0;
            rst_b = 1'h0;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            rst_b = 1'h1;
            @(negedge sys_clk);
            check(18'(q_oe), 18'h0);
            check(q, 18'h0);
            repeat (10) @(negedge sys_clk);
            c_live = 1'h1;
            // first sixteen passes walk every mask pair, edges of address
            for (int n = 0; n < 24; n++) begin
                p0 = 18'($urandom);
                p1 = 18'($urandom);
                n0 = 18'($urandom);
                n1 = 18'($urandom);
                {m1, m0} = n < 16 ? 4'(n) : 4'($urandom);
                a = n == 0 ? 6'h00 : n == 1 ? 6'h3f : 6'($urandom);
                bwlm_ctrl_model_i.cyc(1'h1, 1'h0, a, p0, 2'h0, p1, 2'h0);
                bwlm_ctrl_model_i.cyc(1'h0, 1'h0, a, n0, m0, n1, m1);
                bwlm_ctrl_model_i.cyc(1'h1, 1'h0, a, ~n0, 2'h3, ~n1, 2'h3);
                check(bwlm_ctrl_model_i.qkb, merge(p0, n0, m0));
                check(18'(bwlm_ctrl_model_i.oekb), 18'h1);
                bwlm_ctrl_model_i.cyc(1'h1, 1'h0, a, ~n0, 2'h3, ~n1, 2'h3);
                check(bwlm_ctrl_model_i.qk, merge(p1, n1, m1));
                check(18'(bwlm_ctrl_model_i.oek), 18'h1);
                check(18'(bwlm_ctrl_model_i.oekb), 18'h0);
            end
        end
        close_out();
    end
endmodule
